// ### hw/pdfc_pkg.sv
/*
 Shared constants for the power-down and freeze controller: register map,
 field positions, reset values and sizes.
 Assumes the Avalon-MM slave uses word addresses of 32-bit registers.
*/
package pdfc_pkg;
   // ==========================================================
   // Sizes
   localparam int unsigned NUM_CELLS   = 8;
   localparam int unsigned NUM_PINS    = 8;
   localparam int unsigned SIG_W       = 16;
   localparam int unsigned ADDR_W      = 4;
   localparam int unsigned IDLE_CYC    = 16;
   localparam int unsigned IDLE_W      = 5;
   localparam int unsigned INIT_CYC    = 4;
   localparam int unsigned INIT_W      = 3;
   localparam int unsigned PATTERN_W   = 32;
   localparam int unsigned PAT_DEPTH   = 8;
   localparam int unsigned PAT_AW      = 3;

   // ==========================================================
   // Register word offsets
   localparam logic [ADDR_W-1:0] REG_CTRL      = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STATUS    = 4'h1;
   localparam logic [ADDR_W-1:0] REG_CELL_PWR  = 4'h2;
   localparam logic [ADDR_W-1:0] REG_SLEW_FAST = 4'h3;
   localparam logic [ADDR_W-1:0] REG_OUT_POL   = 4'h4;
   localparam logic [ADDR_W-1:0] REG_SIG       = 4'h5;
   localparam logic [ADDR_W-1:0] REG_PAT_ADDR  = 4'h6;
   localparam logic [ADDR_W-1:0] REG_PAT_DATA  = 4'h7;
   localparam logic [ADDR_W-1:0] REG_LOGIC_IN  = 4'h8;
   localparam logic [ADDR_W-1:0] REG_LOGIC_OUT = 4'h9;

   // ==========================================================
   // Control register bits
   localparam int unsigned CTRL_USE_A    = 0;
   localparam int unsigned CTRL_USE_B    = 1;
   localparam int unsigned CTRL_STANDBY  = 2;
   localparam int unsigned CTRL_KEEPER   = 3;
   localparam int unsigned CTRL_SECURE   = 4;
   localparam int unsigned CTRL_W        = 5;

   // Status register bits
   localparam int unsigned ST_SLEEP      = 0;
   localparam int unsigned ST_STANDBY    = 1;
   localparam int unsigned ST_INIT       = 2;
   localparam int unsigned ST_SECURE     = 3;
   localparam int unsigned ST_REFUSED    = 4;

   // Reset values
   localparam logic [CTRL_W-1:0]    CTRL_RST = 5'h00;
   localparam logic [NUM_PINS-1:0]  SLEW_RST = 8'h00;
   localparam logic [NUM_PINS-1:0]  POL_RST  = 8'h00;
   localparam logic [NUM_CELLS-1:0] CPWR_RST = 8'h00;
   localparam logic [SIG_W-1:0]     SIG_RST  = 16'h0000;
   localparam logic [31:0]          RD_ZERO  = 32'h0000_0000;

   typedef enum logic [1:0] {
      PDFC_INIT,
      PDFC_RUN,
      PDFC_STANDBY,
      PDFC_SLEEP
   } pdfc_state_t;
endpackage

// ### hw/pdfc_pat_if.sv
/*
 Interface carrying pattern memory access between the controller and its
 pattern store.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/10ps
`default_nettype none
interface pdfc_pat_if;
   logic                            we;
   logic [pdfc_pkg::PAT_AW-1:0]     addr;
   logic [pdfc_pkg::PATTERN_W-1:0]  wdata;
   logic [pdfc_pkg::PATTERN_W-1:0]  rdata;
   modport ctrl (output we, output addr, output wdata, input rdata);
   modport mem  (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ### hw/pdfc_pat_mem.sv
/*
 Small configuration pattern store with registered read data.
 Gates writes and read data with the clock enable itself.
*/
`timescale 1ns/10ps
`default_nettype none
module pdfc_pat_mem (
   input  wire logic    clk,     // System clock
   input  wire logic    ce,      // Clock enable
   pdfc_pat_if.mem      bus      // Access port
);
   logic [pdfc_pkg::PATTERN_W-1:0] mem [pdfc_pkg::PAT_DEPTH];

   // ==========================================================
   // Storage
   always_ff @(posedge clk) begin
      if (ce) begin
         if (bus.we) begin
            mem[bus.addr] <= bus.wdata;
         end
         bus.rdata <= mem[bus.addr];
      end
   end
endmodule
`default_nettype wire

// ### hw/pdfc_top.sv
/*
 Power-down, standby and freeze controller with pin keepers, per-cell power,
 slew settings, power-up initialization and a secured pattern readback.
 Assumes sleep pins arrive asynchronously and software uses Avalon-MM.
*/
// The register addresses and the Avalon-MM register port are this design's own decisions.
// Operation
// RULE1 - Enabled sleep pin high on either input forces power-down.
// RULE2 - During power-down internal state and enabled outputs hold entry values.
// RULE3 - During power-down pin transitions are ignored until the pin falls.
// RULE4 - A pin used for sleep is not a logic input or output.
// RULE5 - Standby option: idle logic enters standby, activity resumes operation.
// RULE6 - Each macrocell has its own reduced-power setting.
// RULE7 - Each output has a slew setting, slow unless selected fast.
// RULE8 - Power-up initializes registers; outputs follow configured buffer polarity.
// RULE9 - System keeps clock stable and meets setup after power-up reset.
// RULE10 - Keeper option holds undriven pins at their last driven level.
// RULE11 - Secured device refuses pattern readback; signature stays readable.
// RULE12 - Leaving power-down resumes from held state without reinitialization.
`timescale 1ns/10ps
`default_nettype none
module pdfc_top (
   input  wire logic                              clk,             // 10 MHz clock
   input  wire logic                              rst_n,           // Power-up reset, async low
   input  wire logic                              ce,              // Clock enable
   input  wire logic [pdfc_pkg::ADDR_W-1:0]       avs_address,     // Word address
   input  wire logic                              avs_read,        // Read request
   input  wire logic                              avs_write,       // Write request
   input  wire logic [31:0]                       avs_writedata,   // Write data
   input  wire logic [3:0]                        avs_byteenable,  // Byte lanes
   output logic [31:0]                            avs_readdata,    // Read data
   output logic                                   avs_waitrequest, // Stall
   input  wire logic                              sleep_pin_a,     // Power-down pin A
   input  wire logic                              sleep_pin_b,     // Power-down pin B
   input  wire logic [pdfc_pkg::NUM_PINS-1:0]     pin_in,          // Logic pin level
   input  wire logic [pdfc_pkg::NUM_PINS-1:0]     pin_driven,      // Pin is driven externally
   output logic [pdfc_pkg::NUM_PINS-1:0]          pin_out,         // Output pin value
   output logic [pdfc_pkg::NUM_PINS-1:0]          pin_oe_n,        // Output enable, low drives
   output logic [pdfc_pkg::NUM_PINS-1:0]          pin_slew_fast,   // Fast edge select per pin
   output logic [pdfc_pkg::NUM_CELLS-1:0]         cell_low_power,  // Reduced power per cell
   output logic                                   sleeping,        // Power-down active
   output logic                                   standby          // Standby active
);
   localparam int unsigned NP = pdfc_pkg::NUM_PINS;
   localparam int unsigned NC = pdfc_pkg::NUM_CELLS;

   pdfc_pkg::pdfc_state_t         state;
   logic [pdfc_pkg::CTRL_W-1:0]   ctrl;
   logic [NP-1:0]                 slew_fast;
   logic [NP-1:0]                 out_pol;
   logic [NC-1:0]                 cell_pwr;
   logic [pdfc_pkg::SIG_W-1:0]    signature;
   logic [pdfc_pkg::PAT_AW-1:0]   pat_addr;
   logic [NP-1:0]                 logic_out;
   logic [NP-1:0]                 out_en;
   logic                          refused;
   logic [2:0]                    sa_sync;
   logic [2:0]                    sb_sync;
   logic [NP-1:0]                 pin_s1;
   logic [NP-1:0]                 pin_s2;
   logic [NP-1:0]                 pin_s3;
   logic [NP-1:0]                 drv_s1;
   logic [NP-1:0]                 drv_s2;
   logic [NP-1:0]                 drv_s3;
   logic [NP-1:0]                 pin_level;
   logic [NP-1:0]                 pin_prev;
   logic [pdfc_pkg::IDLE_W-1:0]   idle_cnt;
   logic [pdfc_pkg::INIT_W-1:0]   init_cnt;
   logic                          rd_pend;
   logic                          sleep_req;
   logic                          frozen;
   logic                          activity;
   logic                          wr_hit;
   logic                          rd_hit;
   logic [NP-1:0]                 sleep_pin_mask;
   logic [31:0]                   next_readdata;

   pdfc_pat_if pat ();

   pdfc_pat_mem u_pat (
      .clk (clk),
      .ce  (ce),
      .bus (pat)
   );

   // ==========================================================
   // Pin synchronizers, three stages, change counts when 2 and 3 agree; a sleep pin releases once stage 2 falls
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sa_sync <= 3'h0;
         sb_sync <= 3'h0;
         pin_s1  <= '0;
         pin_s2  <= '0;
         pin_s3  <= '0;
         drv_s1  <= '0;
         drv_s2  <= '0;
         drv_s3  <= '0;
      end else if (ce) begin
         sa_sync <= {sa_sync[1:0], sleep_pin_a};
         sb_sync <= {sb_sync[1:0], sleep_pin_b};
         pin_s1  <= pin_in;
         pin_s2  <= pin_s1;
         pin_s3  <= pin_s2;
         drv_s1  <= pin_driven;
         drv_s2  <= drv_s1;
         drv_s3  <= drv_s2;
      end
   end

   // Either enabled pin, once stable, requests power-down
   assign sleep_req = (ctrl[pdfc_pkg::CTRL_USE_A] && sa_sync[1] && sa_sync[2]) ||
                      (ctrl[pdfc_pkg::CTRL_USE_B] && sb_sync[1] && sb_sync[2]); // RULE1
   assign frozen    = (state == pdfc_pkg::PDFC_SLEEP);

   // Pins 0 and 1 double as sleep pins when those inputs are enabled
   always_comb begin
      sleep_pin_mask    = '0;
      sleep_pin_mask[0] = ctrl[pdfc_pkg::CTRL_USE_A]; // RULE4
      sleep_pin_mask[1] = ctrl[pdfc_pkg::CTRL_USE_B]; // RULE4
   end

   // ==========================================================
   // Pin level with optional keeper; frozen while asleep
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_level <= '0;
         pin_prev  <= '0;
      end else if (ce && !frozen) begin // RULE3
         for (int i = 0; i < NP; i++) begin
            if ((drv_s2[i] && drv_s3[i]) || !ctrl[pdfc_pkg::CTRL_KEEPER]) begin
               if (pin_s2[i] == pin_s3[i]) begin
                  pin_level[i] <= pin_s3[i];
               end
            end // RULE10
         end
         pin_prev <= pin_level;
      end
   end

   assign activity = (pin_level != pin_prev) || wr_hit;

   // ==========================================================
   // Operating state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state    <= pdfc_pkg::PDFC_INIT;
         init_cnt <= '0;
         idle_cnt <= '0;
      end else if (ce) begin
         case (state)
            pdfc_pkg::PDFC_INIT: begin
               // Registers already cleared; count settles outputs to polarity
               if (init_cnt == 3'(pdfc_pkg::INIT_CYC - 1)) begin
                  state <= pdfc_pkg::PDFC_RUN; // RULE8
               end else begin
                  init_cnt <= init_cnt + 3'h1;
               end
            end
            pdfc_pkg::PDFC_RUN: begin
               if (sleep_req) begin
                  state <= pdfc_pkg::PDFC_SLEEP; // RULE1
               end else if (activity) begin
                  idle_cnt <= '0;
               end else if (ctrl[pdfc_pkg::CTRL_STANDBY]) begin
                  if (idle_cnt == 5'(pdfc_pkg::IDLE_CYC - 1)) begin
                     state <= pdfc_pkg::PDFC_STANDBY; // RULE5
                  end else begin
                     idle_cnt <= idle_cnt + 5'h01;
                  end
               end
            end
            pdfc_pkg::PDFC_STANDBY: begin
               if (sleep_req) begin
                  state <= pdfc_pkg::PDFC_SLEEP;
               end else if (activity || !ctrl[pdfc_pkg::CTRL_STANDBY]) begin
                  state    <= pdfc_pkg::PDFC_RUN; // RULE5
                  idle_cnt <= '0;
               end
            end
            pdfc_pkg::PDFC_SLEEP: begin
               // Return keeps every held value except idle_cnt, which clears; no init pass
               if (!sleep_req) begin
                  state    <= pdfc_pkg::PDFC_RUN; // RULE12
                  idle_cnt <= '0;
               end
            end
            default: state <= pdfc_pkg::PDFC_INIT;
         endcase
      end
   end

   // ==========================================================
   // Register bus; writes ignored while frozen so state holds
   assign wr_hit = avs_write && !avs_waitrequest && !frozen; // RULE2
   assign rd_hit = avs_read && !rd_pend;
   // Reads take one extra cycle for the registered pattern memory
   assign avs_waitrequest = avs_read && !rd_pend;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_pend <= 1'b0;
      end else if (ce) begin
         rd_pend <= rd_hit;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl      <= pdfc_pkg::CTRL_RST; // RULE8
         slew_fast <= pdfc_pkg::SLEW_RST; // RULE7
         out_pol   <= pdfc_pkg::POL_RST;
         cell_pwr  <= pdfc_pkg::CPWR_RST;
         signature <= pdfc_pkg::SIG_RST;
         pat_addr  <= '0;
         logic_out <= '0;
         out_en    <= '0;
      end else if (ce && wr_hit && avs_byteenable[0]) begin
         case (avs_address)
            pdfc_pkg::REG_CTRL: begin
               // Security fuse is one-way: only reset clears it
               ctrl <= avs_writedata[pdfc_pkg::CTRL_W-1:0] |
                       (ctrl & 5'(1 << pdfc_pkg::CTRL_SECURE));
            end
            pdfc_pkg::REG_CELL_PWR:  cell_pwr  <= avs_writedata[NC-1:0]; // RULE6
            pdfc_pkg::REG_SLEW_FAST: slew_fast <= avs_writedata[NP-1:0]; // RULE7
            pdfc_pkg::REG_OUT_POL:   out_pol   <= avs_writedata[NP-1:0];
            pdfc_pkg::REG_SIG:       signature <= avs_writedata[pdfc_pkg::SIG_W-1:0];
            pdfc_pkg::REG_PAT_ADDR:  pat_addr  <= avs_writedata[pdfc_pkg::PAT_AW-1:0];
            pdfc_pkg::REG_LOGIC_OUT: begin
               logic_out <= avs_writedata[NP-1:0];
               out_en    <= avs_writedata[NP+NP-1:NP];
            end
            default: ;
         endcase
      end
   end

   // Pattern store: written and read back only when unsecured
   assign pat.addr  = pat_addr;
   assign pat.wdata = avs_writedata;
   assign pat.we    = wr_hit && (avs_address == pdfc_pkg::REG_PAT_DATA) &&
                      !ctrl[pdfc_pkg::CTRL_SECURE];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         refused <= 1'b0;
      end else if (ce && rd_hit && avs_address == pdfc_pkg::REG_PAT_DATA) begin
         refused <= ctrl[pdfc_pkg::CTRL_SECURE]; // RULE11
      end
   end

   always_comb begin
      next_readdata = pdfc_pkg::RD_ZERO;
      case (avs_address)
         pdfc_pkg::REG_CTRL:      next_readdata[pdfc_pkg::CTRL_W-1:0] = ctrl;
         pdfc_pkg::REG_STATUS: begin
            next_readdata[pdfc_pkg::ST_SLEEP]   = frozen;
            next_readdata[pdfc_pkg::ST_STANDBY] = (state == pdfc_pkg::PDFC_STANDBY);
            next_readdata[pdfc_pkg::ST_INIT]    = (state == pdfc_pkg::PDFC_INIT);
            next_readdata[pdfc_pkg::ST_SECURE]  = ctrl[pdfc_pkg::CTRL_SECURE];
            next_readdata[pdfc_pkg::ST_REFUSED] = refused;
         end
         pdfc_pkg::REG_CELL_PWR:  next_readdata[NC-1:0] = cell_pwr;
         pdfc_pkg::REG_SLEW_FAST: next_readdata[NP-1:0] = slew_fast;
         pdfc_pkg::REG_OUT_POL:   next_readdata[NP-1:0] = out_pol;
         pdfc_pkg::REG_SIG:       next_readdata[pdfc_pkg::SIG_W-1:0] = signature; // RULE11
         pdfc_pkg::REG_PAT_ADDR:  next_readdata[pdfc_pkg::PAT_AW-1:0] = pat_addr;
         pdfc_pkg::REG_PAT_DATA: begin
            if (!ctrl[pdfc_pkg::CTRL_SECURE]) begin
               next_readdata = pat.rdata; // RULE11
            end
         end
         pdfc_pkg::REG_LOGIC_IN:  next_readdata[NP-1:0] = pin_level & ~sleep_pin_mask; // RULE4
         pdfc_pkg::REG_LOGIC_OUT: next_readdata[NP+NP-1:0] = {out_en, logic_out};
         default: next_readdata = pdfc_pkg::RD_ZERO;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= pdfc_pkg::RD_ZERO;
      end else if (ce && rd_hit) begin
         avs_readdata <= next_readdata;
      end
   end

   // ==========================================================
   // Pin outputs, registered and held while asleep
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out        <= '0; // RULE8
         pin_oe_n       <= '1;
         pin_slew_fast  <= '0;
         cell_low_power <= '0;
         sleeping       <= 1'b0;
         standby        <= 1'b0;
      end else if (ce) begin
         if (!frozen) begin // RULE2
            pin_out       <= (logic_out ^ out_pol) & ~sleep_pin_mask; // RULE8
            pin_oe_n      <= ~(out_en & ~sleep_pin_mask); // RULE4
            pin_slew_fast <= slew_fast; // RULE7
         end
         cell_low_power <= cell_pwr; // RULE6
         sleeping       <= frozen;
         standby        <= (state == pdfc_pkg::PDFC_STANDBY);
      end
   end
endmodule
`default_nettype wire

// ### dv/pdfc_top_chk.sv
/*
 Port checker for the power-down and freeze controller.
 Assumes one clock domain and is bound to every pdfc_top instance.
*/
`timescale 1ns/10ps
`default_nettype none
module pdfc_top_chk (
   input wire logic                          clk,            // Clock
   input wire logic                          rst_n,          // Async reset
   input wire logic                          avs_write,      // Write request
   input wire logic                          sleep_pin_a,    // Power-down pin A
   input wire logic                          sleep_pin_b,    // Power-down pin B
   input wire logic [pdfc_pkg::NUM_PINS-1:0] pin_in,         // Pin levels
   input wire logic [pdfc_pkg::NUM_PINS-1:0] pin_out,        // Output values
   input wire logic [pdfc_pkg::NUM_PINS-1:0] pin_oe_n,       // Output enables
   input wire logic [pdfc_pkg::NUM_PINS-1:0] pin_slew_fast,  // Slew selects
   input wire logic [pdfc_pkg::NUM_CELLS-1:0] cell_low_power, // Cell power
   input wire logic                          sleeping,       // Power-down
   input wire logic                          standby         // Standby
);
   // ==========================================================
   // Idle tracking
   // Raw quiet cycles; the design's count lags its synchronizers
   logic [7:0] idle_cnt;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         idle_cnt <= 8'h00;
      else if (avs_write || $changed(pin_in))
         idle_cnt <= 8'h00;
      else if (idle_cnt != 8'hff)
         idle_cnt <= idle_cnt + 8'h01;
   end

   // ==========================================================
   // Properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence pins_quiet;
      (!sleep_pin_a && !sleep_pin_b) [*8];
   endsequence
   sequence held_sleep;
      sleeping ##1 sleeping;
   endsequence
   sequence pins_held;
      (sleep_pin_a && sleep_pin_b) [*4] ##0 sleeping;
   endsequence

   pin_cause_a:   assert property (pins_quiet |-> !sleeping)
      else $error("power-down without a pin");
   freeze_out_a:  assert property (held_sleep |-> $stable(pin_out) && $stable(pin_oe_n))
      else $error("outputs moved in power-down");
   freeze_cfg_a:  assert property (held_sleep |-> $stable(cell_low_power) && $stable(pin_slew_fast))
      else $error("settings moved in power-down");
   sleep_hold_a:  assert property (pins_held |=> sleeping)
      else $error("power-down left with pins high");
   standby_idle_a: assert property ($rose(standby) |-> idle_cnt >= 8'h0a)
      else $error("standby entered while busy");
   standby_wake_a: assert property (standby && avs_write |-> ##[1:6] !standby)
      else $error("standby kept after activity");
   cell_write_a:  assert property ($changed(cell_low_power) |-> $past(avs_write, 2))
      else $error("cell power changed without a write");
   slew_write_a:  assert property ($changed(pin_slew_fast) |-> $past(avs_write, 2))
      else $error("slew changed without a write");
   reset_state_a: assert property ($rose(rst_n) |-> pin_oe_n == '1 && !sleeping && cell_low_power == '0)
      else $error("outputs not initialized");
   wake_kept_a:   assert property ($fell(sleeping) |-> $stable(pin_out) && $stable(cell_low_power))
      else $error("state lost on wake");
endmodule

bind pdfc_top pdfc_top_chk i_pdfc_top_chk (.clk(clk), .rst_n(rst_n), .avs_write(avs_write),
   .sleep_pin_a(sleep_pin_a), .sleep_pin_b(sleep_pin_b), .pin_in(pin_in), .pin_out(pin_out),
   .pin_oe_n(pin_oe_n), .pin_slew_fast(pin_slew_fast), .cell_low_power(cell_low_power),
   .sleeping(sleeping), .standby(standby));
`default_nettype wire

// ### dv/pdfc_ext.sv
/*
 Model of the system logic that drives the sleep pins and logic pins.
 Assumes the bench sets wanted levels just after a rising clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module pdfc_ext (
   input  wire logic       clk,         // System clock
   input  wire logic       rst_n,       // Power-up reset
   input  wire logic [1:0] want_sleep,  // Wanted sleep levels, bit 0 is pin A
   input  wire logic [7:0] drv_lvl,     // Levels for driven pins
   input  wire logic [7:0] drv_en,      // Pins driven by this model
   output logic            sleep_pin_a, // Power-down pin A
   output logic            sleep_pin_b, // Power-down pin B
   output logic [7:0]      pin_in,      // Pin levels seen by the device
   output logic [7:0]      pin_driven   // Pins actively driven
);
   // ==========================================================
   // Pin drive
   // Quiet during reset and changes one edge after a request, so setup holds
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_pin_a <= 1'b0;
         sleep_pin_b <= 1'b0;
         pin_in      <= 8'h00;
         pin_driven  <= 8'h00;
      end else begin
         sleep_pin_a <= want_sleep[0];
         sleep_pin_b <= want_sleep[1];
         pin_driven  <= drv_en;
         // No pull on released pins: they flip every cycle
         pin_in      <= (drv_lvl & drv_en) | (~pin_in & ~drv_en);
      end
   end
endmodule
`default_nettype wire

// ### dv/tb_pdfc_top.sv
/*
 Self-checking bench for the power-down and freeze controller.
 Assumes the bound checker and the pin model pdfc_ext.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("wrong value at %0t: %h vs %h", $time, (g), (e)); end end
module tb_pdfc_top;
   logic        clk, rst_n, ce, avs_read, avs_write, avs_waitrequest, sleep_pin_a, sleep_pin_b, sleeping, standby;
   logic [3:0]  avs_address, avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, d;
   logic [7:0]  pin_in, pin_driven, pin_out, pin_oe_n, pin_slew_fast, cell_low_power, drv_lvl, drv_en, po, oe, v;
   logic [1:0]  want_sleep;
   logic [31:0] m [16];
   logic [3:0]  ra [5] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h9};
   logic [31:0] rm [5] = '{32'hff, 32'hff, 32'hff, 32'hffff, 32'hffff};
   int          n_errors, comparisons, cycles;

   pdfc_top i_pdfc_top (.clk(clk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sleep_pin_a(sleep_pin_a),
      .sleep_pin_b(sleep_pin_b), .pin_in(pin_in), .pin_driven(pin_driven), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pin_slew_fast(pin_slew_fast), .cell_low_power(cell_low_power), .sleeping(sleeping), .standby(standby));
   pdfc_ext i_pdfc_ext (.clk(clk), .rst_n(rst_n), .want_sleep(want_sleep), .drv_lvl(drv_lvl), .drv_en(drv_en),
      .sleep_pin_a(sleep_pin_a), .sleep_pin_b(sleep_pin_b), .pin_in(pin_in), .pin_driven(pin_driven));

   // ==========================================================
   // Clock, timeout and verdict
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("comparisons %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ==========================================================
   // Bus master
   task automatic wait_ack();
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
   endtask
   task automatic bus_wr(input logic [3:0] a, input logic [31:0] wd);
      avs_address   <= a;
      avs_writedata <= wd;
      avs_write     <= 1'b1;
      wait_ack();
      avs_write     <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
      avs_address <= a;
      avs_read    <= 1'b1;
      wait_ack();
      avs_read    <= 1'b0;
      `CHK(avs_readdata, e)
      @(posedge clk);
   endtask
   task automatic wait_sleep(input logic lvl);
      @(negedge clk);
      for (int n = 0; n < 12 && sleeping !== lvl; n++)
         @(negedge clk);
   endtask

   // ==========================================================
   // Scenarios
   initial begin
      clk            = 1'b0;
      rst_n          = 1'b0;
      ce             = 1'b1;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_address    = 4'h0;
      avs_writedata  = 32'h0;
      avs_byteenable = 4'hf;
      want_sleep     = 2'b00;
      drv_lvl        = 8'h00;
      drv_en         = 8'hff;
      n_errors       = 0;
      comparisons    = 0;
      cycles         = 0;
      void'($urandom(29939));
      repeat (2) @(posedge clk);
      @(negedge clk);
      `CHK(pin_oe_n, 8'hff)
      @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(4'h1, 32'h4);
      repeat (6) @(posedge clk);
      for (int a = 0; a < 16; a++)
         if (a != 7)
            rd_chk(a[3:0], 32'h0);
      for (int r = 0; r < 3; r++) begin
         foreach (ra[i]) begin
            m[ra[i]] = $urandom & rm[i];
            bus_wr(ra[i], m[ra[i]]);
         end
         avs_byteenable <= 4'he;
         bus_wr(4'h2, $urandom);
         avs_byteenable <= 4'hf;
         bus_wr(4'hc, $urandom);
         foreach (ra[i]) rd_chk(ra[i], m[ra[i]]);
         rd_chk(4'hc, 32'h0);
         @(negedge clk);
         `CHK(cell_low_power, m[2][7:0])
         `CHK(pin_slew_fast, m[3][7:0])
         `CHK(pin_out, m[9][7:0] ^ m[4][7:0])
         `CHK(pin_oe_n, ~m[9][15:8])
         @(posedge clk);
      end
      bus_wr(4'h0, 32'h8);
      v = $urandom & 8'hfc;
      drv_lvl <= v;
      repeat (6) @(posedge clk);
      drv_en <= 8'h03;
      repeat (6) @(posedge clk);
      rd_chk(4'h8, {24'h0, v});
      bus_wr(4'h0, 32'h0);
      drv_en <= 8'hff;
      v = $urandom & 8'hfc;
      drv_lvl <= v;
      repeat (6) @(posedge clk);
      rd_chk(4'h8, {24'h0, v});
      for (int p = 0; p < 2; p++) begin
         bus_wr(4'h0, 32'h1 << p);
         m[9] = ($urandom & 32'hffff) | 32'h0303;
         bus_wr(4'h9, m[9]);
         want_sleep <= 2'b10 >> p;
         repeat (8) @(posedge clk);
         @(negedge clk);
         `CHK(pin_out[p], 1'b0)
         `CHK(sleeping, 1'b0)
         @(posedge clk);
         want_sleep <= 2'b11;
         wait_sleep(1'b1);
         po = pin_out;
         oe = pin_oe_n;
         `CHK(sleeping, 1'b1)
         @(posedge clk);
         bus_wr(4'h9, ~m[9]);
         drv_lvl <= $urandom & 8'hfc;
         repeat (8) @(posedge clk);
         @(negedge clk);
         `CHK(pin_out, po)
         `CHK(pin_oe_n, oe)
         `CHK(sleeping, 1'b1)
         @(posedge clk);
         want_sleep <= 2'b00;
         wait_sleep(1'b0);
         `CHK(pin_out, po)
         @(posedge clk);
         rd_chk(4'h9, m[9]);
         rd_chk(4'h1, 32'h0);
      end
      for (int s = 1; s >= 0; s--) begin
         bus_wr(4'h0, s << 2);
         repeat (30) @(posedge clk);
         @(negedge clk);
         `CHK(standby, s[0])
         @(posedge clk);
         rd_chk(4'h1, s << 1);
      end
      bus_wr(4'h0, 32'h4);
      repeat (30) @(posedge clk);
      bus_wr(4'h3, m[3]);
      repeat (6) @(posedge clk);
      @(negedge clk);
      `CHK(standby, 1'b0)
      @(posedge clk);
      bus_wr(4'h6, $urandom & 32'h7);
      d = $urandom;
      bus_wr(4'h7, d);
      rd_chk(4'h7, d);
      bus_wr(4'h0, 32'h10);
      rd_chk(4'h7, 32'h0);
      rd_chk(4'h1, 32'h18);
      rd_chk(4'h5, m[5]);
      bus_wr(4'h0, 32'h0);
      rd_chk(4'h0, 32'h10);
      complete_run();
   end
endmodule
`default_nettype wire
